// ---- exec_link_if.sv ----
// signals between the execution core, word stepper and marker unit
// assumes the core drives every input side from one always_comb
`timescale 1ns/1ps
`default_nettype none

interface exec_link_if;
  import stack_op_pkg::*;
  word_type           step_in;
  logic               step_down;
  word_type           step_out;
  logic               step_carry;
  logic               step_ovf;
  cc_type             step_cc;
  addr_type           s_now;
  addr_type           q_now;
  word_type           x_now;
  word_type           p_now;
  word_type           status_now;
  logic [1:0]         mark_step;
  word_type           exit_count;
  word_type           delta_word;
  addr_type           mark_addr;
  word_type           mark_word;
  addr_type           exit_q;
  addr_type           exit_s;

  modport core (output step_in, step_down, s_now, q_now, x_now, p_now,
                status_now, mark_step, exit_count, delta_word,
                input step_out, step_carry, step_ovf, step_cc,
                mark_addr, mark_word, exit_q, exit_s);
  modport stepper (input step_in, step_down,
                   output step_out, step_carry, step_ovf, step_cc);
  modport marker (input s_now, q_now, x_now, p_now, status_now,
                  mark_step, exit_count, delta_word,
                  output mark_addr, mark_word, exit_q, exit_s);
endinterface : exec_link_if

`default_nettype wire

// ---- marker_unit.sv ----
// stack marker words for a call and pointer arithmetic for an exit
// assumes the core steps mark_step 0..3 while the old pointers stand
`timescale 1ns/1ps
`default_nettype none

module marker_unit (
  exec_link_if.marker link
);
  import stack_op_pkg::*;

  addr_type new_q;

  always_comb begin
    new_q          = link.s_now + MARKER_WORDS;
    link.mark_addr = link.s_now + {6'h00, link.mark_step} + ADDR_ONE;
    unique case (link.mark_step)
      2'h0: link.mark_word = link.x_now;
      2'h1: link.mark_word = link.p_now + 16'h0001;     // see RL14
      2'h2: link.mark_word = link.status_now;
      default: link.mark_word = {8'h00, new_q - link.q_now}; // see RL15
    endcase
    // exit: frame back by the stored offset, stack past marker and n
    link.exit_q = link.q_now - link.delta_word[ADDR_W-1:0];  // see RL16
    link.exit_s = link.q_now - MARKER_WORDS -
                  link.exit_count[ADDR_W-1:0];               // see RL16
  end

endmodule : marker_unit

`default_nettype wire

// ---- stack_op_exec.sv ----
// stack-op execution unit: stack memory, pointers, index, indicators
// assumes requests come from logic on the same clock, held until ready
//
// Functional notes
// RL1 - indicators change only when the operation names them
// RL2 - no operation changes neither memory nor any indicator
// RL3 - duplicate pushes copy of top word pair, sign class of new pair
// RL4 - clear index writes zero to index, indicators untouched
// RL5 - push null writes one zero word, stack pointer plus one
// RL6 - push double null writes two zero words, indicators untouched
// RL7 - clear second zeroes second word, top and pointer kept
// RL8 - increment index, sign class, carry and overflow updated
// RL9 - decrement index, sign class, carry and overflow updated
// RL10 - increment top word with sign class, carry, overflow
// RL11 - decrement top word with sign class, carry, overflow
// RL12 - increment second word, top kept, indicators updated
// RL13 - decrement second word, top kept, indicators updated
// RL14 - call stores return word: address after the call
// RL15 - marker holds frame back-offset; stack and frame point at its end
// RL16 - exit restores frame, drops marker plus n words, reloads counter
// RL17 - compare immediate sets condition from top word, then deletes it
// RL18 - call marker is exactly four consecutive stack words
// RL19 - sign class: negative, zero or positive of 16-bit result
// RL20 - overflow on signed wrap, carry is unsigned carry or borrow; decrement sets carry when there is no borrow
`timescale 1ns/1ps
`default_nettype none

module stack_op_exec (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   op_valid,
  input  wire stack_op_pkg::kind_type op_kind,
  input  wire stack_op_pkg::opcode_type op_code,
  input  wire stack_op_pkg::word_type op_operand,
  input  wire stack_op_pkg::addr_type peek_addr,
  output var  logic                   op_ready,
  output var  logic                   op_done,
  output var  stack_op_pkg::addr_type s_ptr,
  output var  stack_op_pkg::addr_type q_ptr,
  output var  stack_op_pkg::word_type index_reg,
  output var  stack_op_pkg::word_type pc_reg,
  output var  stack_op_pkg::cc_type   cond_code,
  output var  logic                   carry_flag,
  output var  logic                   overflow_flag,
  output var  stack_op_pkg::word_type peek_data
);
  import stack_op_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [2:0] {
    st_idle   = 3'h1,
    st_second = 3'h2,
    st_mark   = 3'h4
  } state_type;

  typedef struct packed {
    state_type  state;
    logic       ready;
    logic       done;
    addr_type   s;
    addr_type   q;
    word_type   x;
    word_type   p;
    cc_type     cc;
    logic       carry;
    logic       ovf;
    logic [1:0] step;
    word_type   hold;
    logic       hold_cc;
    word_type   target;
    word_type   peek;
  } core_state_type;

  localparam core_state_type RESET_STATE = '{
    state:   st_idle,
    ready:   1'b1,
    done:    1'b0,
    s:       RESET_S,
    q:       RESET_Q,
    x:       RESET_X,
    p:       RESET_P,
    cc:      RESET_CC,
    carry:   1'b0,
    ovf:     1'b0,
    step:    2'h0,
    hold:    16'h0000,
    hold_cc: 1'b0,
    target:  16'h0000,
    peek:    16'h0000
  };

  core_state_type r_q;
  core_state_type r_d;

  word_type stack_mem [STACK_DEPTH];

  logic     wr_en;
  addr_type wr_addr;
  word_type wr_data;

  addr_type second_addr;
  word_type top_w;
  word_type second_w;
  word_type status_w;

  exec_link_if link ();

  //////////////////////////////////////////////////////////////////////////
  // helpers
  word_stepper u_stepper (
    .link (link.stepper)
  );

  marker_unit u_marker (
    .link (link.marker)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_d         = r_q;
    r_d.done    = 1'b0;
    r_d.peek    = stack_mem[peek_addr];
    wr_en       = 1'b0;
    wr_addr     = r_q.s;
    wr_data     = 16'h0000;
    second_addr = r_q.s - ADDR_ONE;
    top_w       = stack_mem[r_q.s];
    second_w    = stack_mem[second_addr];
    status_w    = 16'h0000;
    status_w[STATUS_CC_LSB +: 2] = r_q.cc;
    status_w[STATUS_CARRY]       = r_q.carry;
    status_w[STATUS_OVF]         = r_q.ovf;

    link.s_now      = r_q.s;
    link.q_now      = r_q.q;
    link.x_now      = r_q.x;
    link.p_now      = r_q.p;
    link.status_now = status_w;
    link.mark_step  = r_q.step;
    link.exit_count = op_operand;
    link.delta_word = stack_mem[r_q.q];

    // stepper operand by opcode
    unique case (op_code)
      OPC_INCREMENT_INDEX, OPC_DECREMENT_INDEX: link.step_in = r_q.x;
      OPC_INCREMENT_SECOND, OPC_DECREMENT_SECOND: link.step_in = second_w;
      default: link.step_in = top_w;
    endcase
    link.step_down = (op_code == OPC_DECREMENT_INDEX) ||
                     (op_code == OPC_DECREMENT_TOP) ||
                     (op_code == OPC_DECREMENT_SECOND);

    unique case (r_q.state)
      st_idle: begin
        if (op_valid) begin
          unique case (op_kind)
            kind_stack: begin
              r_d.done = 1'b1;
              r_d.p    = r_q.p + 16'h0001;
              unique case (op_code)
                OPC_NO_OPERATION: begin
                  r_d.p = r_q.p + 16'h0001;               // see RL2
                end
                OPC_DUPLICATE_DOUBLE: begin
                  wr_en       = 1'b1;                     // see RL3
                  wr_addr     = r_q.s + ADDR_ONE;
                  wr_data     = second_w;
                  r_d.hold    = top_w;
                  r_d.hold_cc = 1'b1;
                  r_d.done    = 1'b0;
                  r_d.ready   = 1'b0;
                  r_d.p       = r_q.p;
                  r_d.state   = st_second;
                end
                OPC_CLEAR_INDEX: begin
                  r_d.x = 16'h0000;                       // see RL4
                end
                OPC_PUSH_NULL: begin
                  wr_en   = 1'b1;                         // see RL5
                  wr_addr = r_q.s + ADDR_ONE;
                  wr_data = 16'h0000;
                  r_d.s   = r_q.s + ADDR_ONE;
                end
                OPC_PUSH_DOUBLE_NULL: begin
                  wr_en       = 1'b1;                     // see RL6
                  wr_addr     = r_q.s + ADDR_ONE;
                  wr_data     = 16'h0000;
                  r_d.hold    = 16'h0000;
                  r_d.hold_cc = 1'b0;
                  r_d.done    = 1'b0;
                  r_d.ready   = 1'b0;
                  r_d.p       = r_q.p;
                  r_d.state   = st_second;
                end
                OPC_CLEAR_SECOND_WORD: begin
                  wr_en   = 1'b1;                         // see RL7
                  wr_addr = second_addr;
                  wr_data = 16'h0000;
                end
                OPC_INCREMENT_INDEX, OPC_DECREMENT_INDEX: begin
                  r_d.x     = link.step_out;              // see RL8
                  r_d.cc    = link.step_cc;               // see RL9
                  r_d.carry = link.step_carry;
                  r_d.ovf   = link.step_ovf;
                end
                OPC_INCREMENT_TOP, OPC_DECREMENT_TOP: begin
                  wr_en     = 1'b1;                       // see RL10
                  wr_addr   = r_q.s;                      // see RL11
                  wr_data   = link.step_out;
                  r_d.cc    = link.step_cc;
                  r_d.carry = link.step_carry;
                  r_d.ovf   = link.step_ovf;
                end
                OPC_INCREMENT_SECOND, OPC_DECREMENT_SECOND: begin
                  wr_en     = 1'b1;                       // see RL12
                  wr_addr   = second_addr;                // see RL13
                  wr_data   = link.step_out;
                  r_d.cc    = link.step_cc;
                  r_d.carry = link.step_carry;
                  r_d.ovf   = link.step_ovf;
                end
                default: begin
                  // other groups: only the counter moves   see RL1
                  r_d.p = r_q.p + 16'h0001;
                end
              endcase
            end
            kind_call: begin
              r_d.target = op_operand;
              r_d.step   = 2'h0;
              r_d.ready  = 1'b0;
              r_d.state  = st_mark;
            end
            kind_exit: begin
              r_d.q    = link.exit_q;                     // see RL16
              r_d.s    = link.exit_s;
              r_d.p    = stack_mem[r_q.q - RETURN_BACK];
              r_d.done = 1'b1;
            end
            kind_compare_immediate: begin
              r_d.cc   = compare_class(top_w, op_operand); // see RL17
              r_d.s    = second_addr;
              r_d.p    = r_q.p + 16'h0001;
              r_d.done = 1'b1;
            end
            default: begin
              r_d.done = 1'b1;
            end
          endcase
        end
      end
      st_second: begin
        wr_en     = 1'b1;
        wr_addr   = r_q.s + ADDR_TWO;
        wr_data   = r_q.hold;
        r_d.s     = r_q.s + ADDR_TWO;
        r_d.p     = r_q.p + 16'h0001;
        r_d.done  = 1'b1;
        r_d.ready = 1'b1;
        r_d.state = st_idle;
        if (r_q.hold_cc) begin
          // high word is the copied second word         see RL3
          if (stack_mem[r_q.s + ADDR_ONE][WORD_W-1]) begin
            r_d.cc = cc_less;
          end else if ((stack_mem[r_q.s + ADDR_ONE] == '0) &&
                       (r_q.hold == '0)) begin
            r_d.cc = cc_equal;
          end else begin
            r_d.cc = cc_greater;
          end
        end
      end
      st_mark: begin
        wr_en    = 1'b1;                                  // see RL18
        wr_addr  = link.mark_addr;
        wr_data  = link.mark_word;                        // see RL14
        r_d.step = r_q.step + 2'h1;
        if (r_q.step == 2'h3) begin
          r_d.s     = r_q.s + MARKER_WORDS;               // see RL15
          r_d.q     = r_q.s + MARKER_WORDS;
          r_d.p     = r_q.target;
          r_d.step  = 2'h0;
          r_d.done  = 1'b1;
          r_d.ready = 1'b1;
          r_d.state = st_idle;
        end
      end
      default: begin
        r_d = RESET_STATE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_q <= RESET_STATE;
    end else begin
      r_q <= r_d;
    end
  end

  always_ff @(posedge clk) begin
    if (resetn && wr_en) begin
      stack_mem[wr_addr] <= wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    op_ready      = r_q.ready;
    op_done       = r_q.done;
    s_ptr         = r_q.s;
    q_ptr         = r_q.q;
    index_reg     = r_q.x;
    pc_reg        = r_q.p;
    cond_code     = r_q.cc;
    carry_flag    = r_q.carry;
    overflow_flag = r_q.ovf;
    peek_data     = r_q.peek;
  end

endmodule : stack_op_exec

`default_nettype wire

// ---- stack_op_exec_sva.sv ----
// port checker of the stack-op execution unit
// assumes one clock and a synchronous active-low reset, bound below
`timescale 1ns/1ps
`default_nettype none

module stack_op_exec_sva
  import stack_op_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire logic                     op_valid,
  input wire stack_op_pkg::kind_type   op_kind,
  input wire stack_op_pkg::opcode_type op_code,
  input wire stack_op_pkg::word_type   op_operand,
  input wire stack_op_pkg::addr_type   peek_addr,
  input wire logic                     op_ready,
  input wire logic                     op_done,
  input wire stack_op_pkg::addr_type   s_ptr,
  input wire stack_op_pkg::addr_type   q_ptr,
  input wire stack_op_pkg::word_type   index_reg,
  input wire stack_op_pkg::word_type   pc_reg,
  input wire stack_op_pkg::cc_type     cond_code,
  input wire logic                     carry_flag,
  input wire logic                     overflow_flag,
  input wire stack_op_pkg::word_type   peek_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////
  // taken requests
  wire logic tk;
  wire logic st;
  assign tk = op_valid && op_ready;
  assign st = tk && op_kind == kind_stack;

  ////////////////////////////////////////////////////////////////////////
  // properties
  property p_idle;
    op_ready && !op_valid |=>
      $stable({cond_code, carry_flag, overflow_flag});
  endproperty
  a_idle: assert property (p_idle)
    else $error("indicators moved while idle");

  property p_nop;
    st && op_code == OPC_NO_OPERATION |=> $stable(s_ptr) &&
      $stable(index_reg) && $stable({cond_code, carry_flag, overflow_flag});
  endproperty
  a_nop: assert property (p_nop)
    else $error("no operation changed state");

  property p_dup;
    st && op_code == OPC_DUPLICATE_DOUBLE |=>
      !op_ready ##1 op_done && s_ptr == $past(s_ptr, 2) + ADDR_TWO;
  endproperty
  a_dup: assert property (p_dup)
    else $error("duplicate pointer wrong");

  property p_clear_x;
    st && op_code == OPC_CLEAR_INDEX |=> index_reg == 16'h0000 &&
      $stable(cond_code) && $stable(carry_flag);
  endproperty
  a_clear_x: assert property (p_clear_x)
    else $error("clear index wrong");

  property p_push_null;
    st && op_code == OPC_PUSH_NULL |=>
      op_done && s_ptr == $past(s_ptr) + ADDR_ONE;
  endproperty
  a_push_null: assert property (p_push_null)
    else $error("push null pointer wrong");

  property p_push_dbl;
    st && op_code == OPC_PUSH_DOUBLE_NULL |=> !op_ready ##1 op_done &&
      s_ptr == $past(s_ptr, 2) + ADDR_TWO && $stable(cond_code);
  endproperty
  a_push_dbl: assert property (p_push_dbl)
    else $error("push double null wrong");

  property p_clear_b;
    st && op_code == OPC_CLEAR_SECOND_WORD |=> $stable(s_ptr) &&
      $stable({cond_code, carry_flag, overflow_flag});
  endproperty
  a_clear_b: assert property (p_clear_b)
    else $error("clear second changed state");

  property p_increment_index;
    st && op_code == OPC_INCREMENT_INDEX |=>
      index_reg == $past(index_reg) + 16'h0001 &&
      overflow_flag == ($past(index_reg) == 16'h7FFF) &&
      carry_flag == ($past(index_reg) == 16'hFFFF) &&
      cond_code == (index_reg[15] ? cc_less :
                    (index_reg == 16'h0000 ? cc_equal : cc_greater));
  endproperty
  a_increment_index: assert property (p_increment_index)
    else $error("increment index wrong");

  property p_decrement_index;
    st && op_code == OPC_DECREMENT_INDEX |=>
      index_reg == $past(index_reg) - 16'h0001 &&
      overflow_flag == ($past(index_reg) == 16'h8000) &&
      carry_flag == ($past(index_reg) != 16'h0000);
  endproperty
  a_decrement_index: assert property (p_decrement_index)
    else $error("decrement index wrong");

  property p_call;
    tk && op_kind == kind_call |=> !op_ready [*4] ##1 op_done &&
      s_ptr == q_ptr && s_ptr == $past(s_ptr, 5) + MARKER_WORDS &&
      pc_reg == $past(op_operand, 5);
  endproperty
  a_call: assert property (p_call)
    else $error("call pointers wrong");

  property p_exit;
    tk && op_kind == kind_exit |=> op_done && $stable(index_reg) &&
      s_ptr == $past(q_ptr) - MARKER_WORDS - $past(op_operand[7:0]);
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit pointer wrong");

  property p_compare_immediate;
    tk && op_kind == kind_compare_immediate |=>
      op_done && s_ptr == $past(s_ptr) - ADDR_ONE;
  endproperty
  a_compare_immediate: assert property (p_compare_immediate)
    else $error("compare immediate pointer wrong");

endmodule : stack_op_exec_sva

bind stack_op_exec stack_op_exec_sva i_sva (
  .clk(clk), .resetn(resetn), .op_valid(op_valid), .op_kind(op_kind),
  .op_code(op_code), .op_operand(op_operand), .peek_addr(peek_addr),
  .op_ready(op_ready), .op_done(op_done), .s_ptr(s_ptr), .q_ptr(q_ptr),
  .index_reg(index_reg), .pc_reg(pc_reg), .cond_code(cond_code),
  .carry_flag(carry_flag), .overflow_flag(overflow_flag),
  .peek_data(peek_data)
);

`default_nettype wire

// ---- stack_op_pkg.sv ----
// constants, types and helper functions of the stack-op execution unit
// assumes one 40 MHz clock and a synchronous active-low reset
`default_nettype none

package stack_op_pkg;

  ////////////////////////////////////////////////////////////////////////
  // widths and sizes
  localparam int WORD_W      = 16;
  localparam int ADDR_W      = 8;
  localparam int STACK_DEPTH = 256;
  localparam int OPC_W       = 6;

  typedef logic [WORD_W-1:0] word_type;
  typedef logic [ADDR_W-1:0] addr_type;
  typedef logic [OPC_W-1:0]  opcode_type;

  ////////////////////////////////////////////////////////////////////////
  // stack opcodes (octal 00 46 03 06 07 41 04 05 33 34 73 74)
  localparam opcode_type OPC_NO_OPERATION        = 6'h00;
  localparam opcode_type OPC_DUPLICATE_DOUBLE    = 6'h26;
  localparam opcode_type OPC_CLEAR_INDEX         = 6'h03;
  localparam opcode_type OPC_PUSH_NULL           = 6'h06;
  localparam opcode_type OPC_PUSH_DOUBLE_NULL    = 6'h07;
  localparam opcode_type OPC_CLEAR_SECOND_WORD   = 6'h21;
  localparam opcode_type OPC_INCREMENT_INDEX     = 6'h04;
  localparam opcode_type OPC_DECREMENT_INDEX     = 6'h05;
  localparam opcode_type OPC_INCREMENT_TOP       = 6'h1B;
  localparam opcode_type OPC_DECREMENT_TOP       = 6'h1C;
  localparam opcode_type OPC_INCREMENT_SECOND    = 6'h3B;
  localparam opcode_type OPC_DECREMENT_SECOND    = 6'h3C;

  typedef enum logic [3:0] {
    kind_stack = 4'h1,
    kind_call  = 4'h2,
    kind_exit  = 4'h4,
    kind_compare_immediate  = 4'h8
  } kind_type;

  typedef enum logic [1:0] {
    cc_greater = 2'h0,
    cc_less    = 2'h1,
    cc_equal   = 2'h2
  } cc_type;

  ////////////////////////////////////////////////////////////////////////
  // stack marker layout, status word fields
  localparam addr_type MARKER_WORDS    = 8'h04;
  localparam addr_type RETURN_BACK     = 8'h02;
  localparam addr_type ADDR_ONE        = 8'h01;
  localparam addr_type ADDR_TWO        = 8'h02;
  localparam int       STATUS_CC_LSB   = 14;
  localparam int       STATUS_CARRY    = 13;
  localparam int       STATUS_OVF      = 12;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam addr_type RESET_S     = 8'h00;
  localparam addr_type RESET_Q     = 8'h00;
  localparam word_type RESET_X     = 16'h0000;
  localparam word_type RESET_P     = 16'h0000;
  localparam cc_type   RESET_CC    = cc_equal;

  ////////////////////////////////////////////////////////////////////////
  // sign classes
  function automatic cc_type sign_class(input word_type v);
    if (v[WORD_W-1]) sign_class = cc_less;
    else if (v == '0) sign_class = cc_equal;
    else sign_class = cc_greater;
  endfunction : sign_class

  function automatic cc_type compare_class(input word_type a,
                                           input word_type b);
    if ($signed(a) < $signed(b)) compare_class = cc_less;
    else if (a == b) compare_class = cc_equal;
    else compare_class = cc_greater;
  endfunction : compare_class

endpackage : stack_op_pkg

`default_nettype wire

// ---- tb_stack_op_exec.sv ----
// self-checking bench of the stack-op execution unit
// assumes stack_op_pkg and the bound port checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_stack_op_exec;
  import stack_op_pkg::*;
  logic       clk, resetn, op_valid, op_ready, op_done;
  logic       carry_flag, overflow_flag, exp_c, exp_v;
  kind_type   op_kind;
  opcode_type op_code;
  word_type   op_operand, index_reg, pc_reg, peek_data, exp_p;
  addr_type   peek_addr, s_ptr, q_ptr, exp_s;
  cc_type     cond_code, exp_cc;
  int         err_total, samples_checked;

  stack_op_exec i_dut (
    .clk(clk), .resetn(resetn), .op_valid(op_valid), .op_kind(op_kind),
    .op_code(op_code), .op_operand(op_operand), .peek_addr(peek_addr),
    .op_ready(op_ready), .op_done(op_done), .s_ptr(s_ptr), .q_ptr(q_ptr),
    .index_reg(index_reg), .pc_reg(pc_reg), .cond_code(cond_code),
    .carry_flag(carry_flag), .overflow_flag(overflow_flag),
    .peek_data(peek_data)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic do_op(input kind_type k, input opcode_type c,
                       input word_type d, input int cyc);
    int n;
    op_valid = 1'b1;
    op_kind = k;
    op_code = c;
    op_operand = d;
    @(negedge clk);
    op_valid = 1'b0;
    n = 1;
    while (op_done !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    check(n, cyc);
    check(s_ptr, exp_s);
    check(pc_reg, exp_p);
    check({cond_code, carry_flag, overflow_flag},
          {exp_cc, exp_c, exp_v});
  endtask : do_op

  task automatic st(input opcode_type c, input int cyc);
    exp_p = exp_p + 16'h0001;
    do_op(kind_stack, c, 16'h0000, cyc);
  endtask : st

  task automatic fl(input cc_type c, input logic cy, input logic v);
    exp_cc = c;
    exp_c = cy;
    exp_v = v;
  endtask : fl

  task automatic peek(input addr_type a, input word_type want);
    peek_addr = a;
    @(negedge clk);
    check(peek_data, want);
  endtask : peek

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_index;
    st(OPC_CLEAR_INDEX, 1);
    check(index_reg, 16'h0000);
    fl(cc_less, 1'b0, 1'b0);
    st(OPC_DECREMENT_INDEX, 1);
    check(index_reg, 16'hFFFF);
    fl(cc_equal, 1'b1, 1'b0);
    st(OPC_INCREMENT_INDEX, 1);
    check(index_reg, 16'h0000);
    st(OPC_CLEAR_INDEX, 1);
    fl(cc_greater, 1'b0, 1'b0);
    for (int i = 0; i < 32767; i++) begin
      st(OPC_INCREMENT_INDEX, 1);
    end
    check(index_reg, 16'h7FFF);
    fl(cc_less, 1'b0, 1'b1);
    st(OPC_INCREMENT_INDEX, 1);
    check(index_reg, 16'h8000);
    fl(cc_greater, 1'b1, 1'b1);
    st(OPC_DECREMENT_INDEX, 1);
    check(index_reg, 16'h7FFF);
    $display("index test done");
  endtask : t_index

  task automatic t_stack;
    exp_s = 8'h01;
    st(OPC_PUSH_NULL, 1);
    peek(8'h01, 16'h0000);
    fl(cc_less, 1'b0, 1'b0);
    st(OPC_DECREMENT_TOP, 1);
    peek(8'h01, 16'hFFFF);
    exp_s = 8'h03;
    st(OPC_PUSH_DOUBLE_NULL, 2);
    peek(8'h02, 16'h0000);
    peek(8'h03, 16'h0000);
    fl(cc_greater, 1'b0, 1'b0);
    st(OPC_INCREMENT_SECOND, 1);
    peek(8'h02, 16'h0001);
    peek(8'h03, 16'h0000);
    fl(cc_equal, 1'b1, 1'b0);
    st(OPC_DECREMENT_SECOND, 1);
    peek(8'h02, 16'h0000);
    fl(cc_greater, 1'b0, 1'b0);
    st(OPC_INCREMENT_TOP, 1);
    peek(8'h03, 16'h0001);
    st(OPC_INCREMENT_SECOND, 1);
    st(OPC_CLEAR_SECOND_WORD, 1);
    peek(8'h02, 16'h0000);
    peek(8'h03, 16'h0001);
    st(OPC_INCREMENT_SECOND, 1);
    fl(cc_equal, 1'b1, 1'b0);
    st(OPC_DECREMENT_TOP, 1);
    exp_s = 8'h05;
    exp_cc = cc_greater;
    st(OPC_DUPLICATE_DOUBLE, 2);
    peek(8'h04, 16'h0001);
    peek(8'h05, 16'h0000);
    st(OPC_NO_OPERATION, 1);
    peek(8'h05, 16'h0000);
    check(index_reg, 16'h7FFF);
    st(6'h01, 1);
    $display("stack test done");
  endtask : t_stack

  task automatic t_call;
    word_type ret;
    exp_s = 8'h04;
    exp_p = exp_p + 16'h0001;
    exp_cc = cc_less;
    do_op(kind_compare_immediate, 6'h00, 16'h0001, 1);
    exp_s = 8'h03;
    exp_p = exp_p + 16'h0001;
    exp_cc = cc_equal;
    do_op(kind_compare_immediate, 6'h00, 16'h0001, 1);
    ret = exp_p + 16'h0001;
    exp_s = 8'h07;
    exp_p = 16'h0040;
    do_op(kind_call, 6'h00, 16'h0040, 5);
    check(q_ptr, 8'h07);
    peek(8'h04, 16'h7FFF);
    peek(8'h05, ret);
    peek(8'h06, 16'hA000);
    peek(8'h07, 16'h0007);
    exp_s = 8'h08;
    st(OPC_PUSH_NULL, 1);
    exp_s = 8'h02;
    exp_p = ret;
    do_op(kind_exit, 6'h00, 16'h0001, 1);
    check(q_ptr, 8'h00);
    $display("call test done");
  endtask : t_call

  ////////////////////////////////////////////////////////////////////////
  // run control
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    err_total = 0;
    samples_checked = 0;
    resetn = 1'b0;
    op_valid = 1'b0;
    op_kind = kind_stack;
    op_code = 6'h00;
    op_operand = 16'h0000;
    peek_addr = 8'h00;
    exp_s = 8'h00;
    exp_p = 16'h0000;
    fl(cc_equal, 1'b0, 1'b0);
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    t_index();
    t_stack();
    t_call();
    report_and_stop();
  end
endmodule : tb_stack_op_exec

`default_nettype wire

// ---- word_stepper.sv ----
// signed increment or decrement of one word with its indicators
// assumes a purely combinational use by the core
`timescale 1ns/1ps
`default_nettype none

module word_stepper (
  exec_link_if.stepper link
);
  import stack_op_pkg::*;

  logic [WORD_W:0] sum;

  always_comb begin
    // adding all ones is a decrement; carry out is the inverted borrow (set when no borrow)
    sum = {1'b0, link.step_in} +
          (link.step_down ? 17'h0FFFF : 17'h00001);
    link.step_out   = sum[WORD_W-1:0];
    link.step_carry = sum[WORD_W];                      // see RL20
    link.step_ovf   = link.step_down ?                  // see RL20
                      (link.step_in == 16'h8000) :
                      (link.step_in == 16'h7FFF);
    link.step_cc    = sign_class(sum[WORD_W-1:0]);      // see RL19
  end

endmodule : word_stepper

`default_nettype wire
